// ==== verilog/reset_sequencer_defs.vh ====
// constants for the reset and wake-up sequencer
// assumes a 40 MHz system clock; command words arrive already deserialised
`ifndef RESET_SEQUENCER_DEFS_VH
`define RESET_SEQUENCER_DEFS_VH

`define CLK_HZ              40000000
`define POR_TIME_MS         150
`define POR_CYCLES          ((`CLK_HZ / 1000) * `POR_TIME_MS)
`define DEBOUNCE_TIME_US    1000
`define DEBOUNCE_CYCLES     ((`CLK_HZ / 1000000) * `DEBOUNCE_TIME_US)
`define SW_RESET_WORD       16'hff00
`define BATT_CMD_MASK       16'hff00
`define BATT_CMD_CODE       16'hc200
`define NORMAL_MODE_BIT     6
`define SERVICE_CYCLES      4

`endif

// ==== verilog/reset_and_wakeup_sequencer.v ====
// reset-source handling and oscillator gating for event servicing
// assumes all inputs are synchronous to clk; porTrigger models the analog
// power-on detector and glitchDetect the supply transient comparator
`include "reset_sequencer_defs.vh"

module reset_and_wakeup_sequencer #(
    parameter NUM_BUTTONS   = 4,
    parameter POR_COUNT     = `POR_CYCLES,
    parameter DEBOUNCE_COUNT = `DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   rst,
    // analog reset sources
    input  wire                   porTrigger,
    input  wire                   glitchDetect,
    // command words and status reads from the serial interface
    input  wire                   cmdValid,
    input  wire [15:0]            cmdWord,
    input  wire                   statusRead,
    // wake sources
    input  wire [NUM_BUTTONS-1:0] push_button_input,
    input  wire                   timerWake,
    input  wire                   lowBatteryWake,
    // outputs
    output reg                    inReset,
    output reg                    cmdAccept,
    output reg                    sensitiveMode,
    output reg                    oscEnable,
    output wire [NUM_BUTTONS-1:0] buttonState,
    output reg                    wakePending,
    output reg                    wakeOverrun
);

    // ==========================================================
    // command decoding
    // ==========================================================
    // a word only counts when the interface is open for commands
    function cmdTaken;
        input valid;
        input accept;
        begin
            cmdTaken = valid && accept;
        end
    endfunction

    function isSwReset;
        input [15:0] word;
        begin
            isSwReset = (word == `SW_RESET_WORD);
        end
    endfunction

    function isBattCmd;
        input [15:0] word;
        begin
            isBattCmd = ((word & `BATT_CMD_MASK) == `BATT_CMD_CODE);
        end
    endfunction

    // ==========================================================
    // reset sources
    // ==========================================================
    wire swReset    = cmdTaken(cmdValid, cmdAccept) && isSwReset(cmdWord);
    wire glitchReq  = glitchDetect && sensitiveMode;
    wire resetReq   = porTrigger || glitchReq || swReset;

    reg [31:0] porCount;
    reg        resetHold;

    // hold the reset for the whole power-on window; a software reset
    // takes the same path so the two cannot differ
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            porCount  <= 32'h0;
            resetHold <= 1'b1;
        end else if (resetReq) begin
            porCount  <= 32'h0;
            resetHold <= 1'b1;
        end else if (resetHold) begin
            if (porCount >= POR_COUNT - 1)
                resetHold <= 1'b0;
            else
                porCount <= porCount + 32'h1;
        end
    end

    // registered release so every configuration flop leaves reset together
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inReset   <= 1'b1;
            cmdAccept <= 1'b0;
        end else begin
            inReset   <= resetHold || resetReq;
            cmdAccept <= !(resetHold || resetReq);
        end
    end

    // ==========================================================
    // configuration
    // ==========================================================
    wire battCmd = cmdTaken(cmdValid, cmdAccept) && isBattCmd(cmdWord);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sensitiveMode <= 1'b1;
        end else if (inReset) begin
            sensitiveMode <= 1'b1;
        end else if (battCmd) begin
            sensitiveMode <= !cmdWord[`NORMAL_MODE_BIT];
        end
    end

    // ==========================================================
    // push-button debounce
    // ==========================================================
    wire [NUM_BUTTONS-1:0] pressEv;
    wire [NUM_BUTTONS-1:0] releaseEv;

    genvar g;
    generate
        for (g = 0; g < NUM_BUTTONS; g = g + 1) begin : gDeb
            reg [31:0] cnt;
            reg        level;
            reg        changed;
            // one always block per button keeps a single driver for each output bit
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt     <= 32'h0;
                    level   <= 1'b0;
                    changed <= 1'b0;
                end else if (inReset) begin
                    cnt     <= 32'h0;
                    level   <= 1'b0;
                    changed <= 1'b0;
                end else if (push_button_input[g] == level) begin
                    cnt     <= 32'h0;
                    changed <= 1'b0;
                end else if (cnt >= DEBOUNCE_COUNT - 1) begin
                    cnt     <= 32'h0;
                    level   <= push_button_input[g];
                    changed <= 1'b1;
                end else begin
                    cnt     <= cnt + 32'h1;
                    changed <= 1'b0;
                end
            end
            assign buttonState[g] = level;
            assign pressEv[g]     = changed && level;
            assign releaseEv[g]   = changed && !level;
        end
    endgenerate

    // ==========================================================
    // oscillator gating and event sequencing
    // ==========================================================
    localparam ST_IDLE    = 2'd0;
    localparam ST_SERVICE = 2'd1;
    localparam ST_HOLD    = 2'd2;

    wire wakeEv    = (|pressEv) || timerWake || lowBatteryWake;
    wire anyEvent  = wakeEv || (|releaseEv) || statusRead;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] svcCount;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (anyEvent)
                    next_state = ST_SERVICE;
            end
            ST_SERVICE: begin
                if (wakeOverrun || (wakePending && wakeEv && !statusRead))
                    next_state = ST_HOLD;
                else if (svcCount >= `SERVICE_CYCLES - 1 && !anyEvent)
                    next_state = ST_IDLE;
            end
            ST_HOLD: begin
                if (statusRead)
                    next_state = ST_SERVICE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            svcCount    <= 8'h0;
            oscEnable   <= 1'b1;
            wakePending <= 1'b0;
            wakeOverrun <= 1'b0;
        end else if (inReset) begin
            // power-on itself counts as a wake event needing service
            state       <= ST_SERVICE;
            svcCount    <= 8'h0;
            oscEnable   <= 1'b1;
            wakePending <= 1'b1;
            wakeOverrun <= 1'b0;
        end else begin
            state <= next_state;
            // events are served one after another: each restarts the window
            if (anyEvent || next_state != ST_SERVICE)
                svcCount <= 8'h0;
            else if (svcCount != 8'hff)
                svcCount <= svcCount + 8'h1;
            oscEnable <= (next_state != ST_IDLE);
            // set beats clear: a wake arriving with the read stays pending
            if (wakeEv)
                wakePending <= 1'b1;
            else if (statusRead)
                wakePending <= 1'b0;
            if (wakeEv && wakePending && !statusRead)
                wakeOverrun <= 1'b1;
            else if (statusRead)
                wakeOverrun <= 1'b0;
        end
    end

endmodule // reset_and_wakeup_sequencer

// ==== sim/seq_properties.sv ====
// port-level checks for the reset and wake-up sequencer
// assumes the sequencer ports as declared, one clock domain
module seq_properties (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // inputs watched
    input wire        porTrigger,
    input wire        glitchDetect,
    input wire        cmdValid,
    input wire [15:0] cmdWord,
    input wire        statusRead,
    input wire        timerWake,
    input wire        lowBatteryWake,
    // outputs watched
    input wire        inReset,
    input wire        cmdAccept,
    input wire        sensitiveMode,
    input wire        oscEnable,
    input wire        wakeOverrun
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire take = cmdValid && cmdAccept;
    a_por_entry: assert property (porTrigger |=> inReset) else $error("no reset on power-on");
    a_cmd_blocked: assert property (inReset |-> !cmdAccept) else $error("cmd taken in reset");
    a_sw_reset: assert property (take && cmdWord == 16'hff00 |=> inReset)
        else $error("no software reset");
    a_normal_mode: assert property (take && cmdWord[15:8] == 8'hc2 && cmdWord[6]
        |=> !sensitiveMode) else $error("normal mode not taken");
    a_glitch_reset: assert property (glitchDetect && sensitiveMode |=> inReset)
        else $error("glitch ignored in sensitive mode");
    a_glitch_off: assert property (glitchDetect && !sensitiveMode && !inReset && !porTrigger
        && !cmdValid |=> !inReset) else $error("glitch reset in normal mode");
    a_reset_hold: assert property ($rose(inReset) |-> inReset[*8])
        else $error("reset too short");
    a_mode_default: assert property ($rose(inReset) |=> sensitiveMode)
        else $error("mode not restored");
    a_wake_osc: assert property ((timerWake || lowBatteryWake) && !inReset |=> oscEnable)
        else $error("oscillator not started");
    a_overrun_hold: assert property (wakeOverrun && !statusRead |=> oscEnable)
        else $error("oscillator dropped before read");
    a_release_sync: assert property ($fell(inReset) |-> cmdAccept)
        else $error("release not aligned");
endmodule // seq_properties
bind reset_and_wakeup_sequencer seq_properties i_seq_properties (.clk(clk), .rst(rst),
    .porTrigger(porTrigger), .glitchDetect(glitchDetect), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .statusRead(statusRead), .timerWake(timerWake),
    .lowBatteryWake(lowBatteryWake), .inReset(inReset), .cmdAccept(cmdAccept),
    .sensitiveMode(sensitiveMode), .oscEnable(oscEnable), .wakeOverrun(wakeOverrun));

// ==== sim/host_model.sv ====
// host controller model: whole command words and status reads
// assumes command words are taken at the rising edge while cmdAccept is high; status reads at any rising edge
module host_model (
    input  wire         clk,
    input  wire         cmdAccept,
    output logic        cmdValid,
    output logic [15:0] cmdWord,
    output logic        statusRead
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmdValid = 1'b0;
        cmdWord = 16'h0000;
        statusRead = 1'b0;
    end
    // send waits at most 200 cycles for cmdAccept; read never waits
    task send(input logic [15:0] w);
        for (int n = 0; n < 200 && cmdAccept !== 1'b1; n++) @(negedge clk);
        cmdValid = 1'b1;
        cmdWord = w;
        @(negedge clk);
        cmdValid = 1'b0;
        cmdWord = ~w;
    endtask
    task read();
        statusRead = 1'b1;
        @(negedge clk);
        statusRead = 1'b0;
    endtask
endmodule // host_model

// ==== sim/tb.sv ====
// scenario bench for the reset and wake-up sequencer
// assumes small counts: power-on window 20, debounce 4
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, porTrigger = 0, glitchDetect = 0, timerWake = 0, lowBatteryWake = 0;
    logic [3:0] push_button_input = 4'h0;
    wire cmdValid, statusRead, inReset, cmdAccept, sensitiveMode, oscEnable, wakePending;
    wire wakeOverrun;
    wire [15:0] cmdWord;
    wire [3:0] buttonState;
    int fails = 0, checked = 0;
    always #12.5 clk = ~clk;
    host_model i_host_model (.clk(clk), .cmdAccept(cmdAccept), .cmdValid(cmdValid), .cmdWord(cmdWord),
        .statusRead(statusRead));
    reset_and_wakeup_sequencer #(.NUM_BUTTONS(4), .POR_COUNT(20), .DEBOUNCE_COUNT(4))
        i_reset_and_wakeup_sequencer (.clk(clk), .rst(rst), .porTrigger(porTrigger),
        .glitchDetect(glitchDetect), .cmdValid(cmdValid), .cmdWord(cmdWord),
        .statusRead(statusRead), .push_button_input(push_button_input), .timerWake(timerWake),
        .lowBatteryWake(lowBatteryWake), .inReset(inReset), .cmdAccept(cmdAccept),
        .sensitiveMode(sensitiveMode), .oscEnable(oscEnable), .buttonState(buttonState),
        .wakePending(wakePending), .wakeOverrun(wakeOverrun));
    task chk(string n, logic [3:0] e, logic [3:0] v);
        checked++;
        if (e !== v) begin
            $display("[ERR] %s expected %h seen %h", n, e, v);
            fails++;
        end
    endtask
    task wait_ready();
        for (int n = 0; n < 60 && cmdAccept !== 1'b1; n++) @(negedge clk);
        chk("cmdAccept", 1, cmdAccept);
    endtask
    task t_por();
        wait_ready();
        chk("sensitiveMode", 1, sensitiveMode);
        chk("wakePending", 1, wakePending);
    endtask
    task t_mode();
        i_host_model.send(16'hc240);
        @(negedge clk);
        chk("sensitiveMode", 0, sensitiveMode);
        glitchDetect = 1;
        @(negedge clk);
        glitchDetect = 0;
        @(negedge clk);
        chk("inReset", 0, inReset);
        i_host_model.send(16'hff00);
        chk("inReset", 1, inReset);
        wait_ready();
        chk("sensitiveMode", 1, sensitiveMode);
    endtask
    task t_sources();
        glitchDetect = 1;
        @(negedge clk);
        glitchDetect = 0;
        chk("inReset", 1, inReset);
        wait_ready();
        porTrigger = 1;
        @(negedge clk);
        porTrigger = 0;
        chk("inReset", 1, inReset);
        wait_ready();
    endtask
    task t_wake();
        i_host_model.read();
        repeat (10) @(negedge clk);
        chk("oscEnable", 0, oscEnable);
        timerWake = 1;
        @(negedge clk);
        timerWake = 0;
        chk("oscEnable", 1, oscEnable);
        lowBatteryWake = 1;
        @(negedge clk);
        lowBatteryWake = 0;
        repeat (10) @(negedge clk);
        chk("wakeOverrun", 1, wakeOverrun);
        chk("oscEnable", 1, oscEnable);
        i_host_model.read();
        repeat (10) @(negedge clk);
        chk("oscEnable", 0, oscEnable);
    endtask
    task t_button();
        push_button_input = 4'h9;
        repeat (2) @(negedge clk);
        chk("buttonState", 4'h0, buttonState);
        repeat (6) @(negedge clk);
        chk("buttonState", 4'h9, buttonState);
        push_button_input = 4'h1;
        repeat (8) @(negedge clk);
        chk("buttonState", 4'h1, buttonState);
    endtask
    task stop_test();
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        t_por();
        t_mode();
        t_sources();
        t_wake();
        t_button();
        stop_test();
    end
    // whole run is well under 1000 cycles
    initial begin
        #100us;
        fails++;
        stop_test();
    end
endmodule // tb
